/* File: verilog/bpeh_pkg.sv */
`default_nettype none
package bpeh_pkg;

	// ----------------------------------------
	// configuration space offsets
	// ----------------------------------------
	localparam logic [7:0] OFF_PRIMARY_COMMAND    = 8'h04;
	localparam logic [7:0] OFF_PRIMARY_STATUS     = 8'h06;
	localparam logic [7:0] OFF_SECONDARY_STATUS   = 8'h1E;
	localparam logic [7:0] OFF_BRIDGE_CONTROL     = 8'h3E;
	localparam logic [7:0] OFF_MISC_OPTIONS       = 8'h46;
	localparam logic [7:0] OFF_SYSERR_EVT_DISABLE = 8'h64;
	localparam logic [7:0] OFF_SYSERR_EVT_STATUS  = 8'h6A;

	// ----------------------------------------
	// field positions
	// ----------------------------------------
	localparam int CMD_PERR_RESP_BIT   = 6;
	localparam int CMD_SERR_EN_BIT     = 8;
	localparam int STAT_MDPE_BIT       = 8;
	localparam int STAT_SIG_SERR_BIT   = 14;
	localparam int STAT_PERR_DET_BIT   = 15;
	localparam int BCTL_PERR_RESP_BIT  = 0;
	localparam int MISC_REGEN_PAR_BIT  = 3;
	localparam int SEDIS_POSTED_WR_BIT = 1;
	localparam int SESTAT_POSTED_WR_BIT = 1;

	// ----------------------------------------
	// reset values and masks
	// ----------------------------------------
	localparam logic [15:0] RST_PRIMARY_COMMAND  = 16'h0000;
	localparam logic [15:0] RST_STATUS           = 16'h0000;
	localparam logic [15:0] RST_BRIDGE_CONTROL   = 16'h0000;
	localparam logic [7:0]  RST_MISC_OPTIONS     = 8'h00;
	localparam logic [7:0]  RST_SYSERR_DISABLE   = 8'h00;
	localparam logic [7:0]  RST_SYSERR_STATUS    = 8'h00;
	localparam logic [15:0] STATUS_W1C_MASK      = 16'hC100;
	localparam logic [7:0]  SESTAT_W1C_MASK      = 8'h02;

	// ----------------------------------------
	// bus commands and data phase kinds
	// ----------------------------------------
	localparam logic [3:0] CMD_SPLIT_COMPLETION = 4'hC;

	typedef enum logic [1:0] {
		BPEH_KIND_NONE        = 2'b00,
		BPEH_KIND_MASTER_READ = 2'b01,
		BPEH_KIND_TARGET_WRITE = 2'b11
	} bpeh_kind_t;

endpackage
`default_nettype wire

/* File: verilog/bpeh_side_chk.sv */
`timescale 1ns/1ps
`default_nettype none
module bpeh_side_chk #(
	parameter int AD_W = 32,
	parameter int BE_W = 4
) (
	input  wire logic                 clk_sys,
	input  wire logic                 nrst,
	input  wire logic                 addr_valid,
	input  wire logic                 attr_valid,
	input  wire logic [AD_W-1:0]      ad,
	input  wire logic [BE_W-1:0]      cbe,
	input  wire logic                 par,
	input  wire logic                 data_valid,
	input  wire bpeh_pkg::bpeh_kind_t data_kind,
	input  wire logic                 perr_pin_n,
	output logic                      addr_err,
	output logic [BE_W-1:0]           cmd,
	output logic                      data_err,
	output bpeh_pkg::bpeh_kind_t      data_kind_q,
	output logic                      perr_rise
);

	// ----------------------------------------
	// parity check
	// ----------------------------------------
	logic                 bad_par;
	logic                 next_addr_err;
	logic [BE_W-1:0]      next_cmd;
	logic                 next_data_err;
	bpeh_pkg::bpeh_kind_t next_data_kind_q;

	assign bad_par = ^{ad, cbe, par};

	always_comb begin
		next_addr_err    = (addr_valid | attr_valid) & bad_par;
		next_cmd         = addr_valid ? cbe : cmd;
		next_data_err    = data_valid & bad_par;
		next_data_kind_q = data_valid ? data_kind : bpeh_pkg::BPEH_KIND_NONE;
	end

	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			addr_err    <= 1'b0;
			cmd         <= '0;
			data_err    <= 1'b0;
			data_kind_q <= bpeh_pkg::BPEH_KIND_NONE;
		end else begin
			addr_err    <= next_addr_err;
			cmd         <= next_cmd;
			data_err    <= next_data_err;
			data_kind_q <= next_data_kind_q;
		end
	end

	// ----------------------------------------
	// parity error pin synchroniser
	// ----------------------------------------
	logic perr_meta;
	logic perr_sync;
	logic perr_last;
	logic next_perr_rise;

	always_comb begin
		next_perr_rise = perr_last & ~perr_sync;
	end

	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			perr_meta <= 1'b1;
			perr_sync <= 1'b1;
			perr_last <= 1'b1;
			perr_rise <= 1'b0;
		end else begin
			perr_meta <= perr_pin_n;
			perr_sync <= perr_meta;
			perr_last <= perr_sync;
			perr_rise <= next_perr_rise;
		end
	end

endmodule
`default_nettype wire

/* File: verilog/bpeh_handler.sv */
// How it works
// - address parity is checked on every address phase of both interfaces.
// - conventional mode: address parity error inhibits claim when response enable set.
// - pci-x mode: split completion received, others target-aborted; neither enters fifos.
// - address parity error sets status bit 15 of that interface, always.
// - primary address parity error raises primary system error when command bits 8,6 set.
// - secondary address parity error raises secondary system error and status bit 14.
// - attribute parity errors are handled like address parity errors.
// - config write with bad parity still writes; sets bit 15; perr if enabled.
// - downstream read bad data parity: secondary perr two clocks later if enabled.
// - downstream read error: secondary bit 15 always, bit 8 only if enabled.
// - upstream read error: primary perr and bit 8 if enabled, bit 15 always.
// - read data returns with received parity unless misc options bit 3 regenerates it.
// - initiator perr during read return causes no action here.
// - downstream posted write bad parity: primary perr if enabled, bit 15, forward.
// - upstream posted write bad parity: secondary perr if enabled, bit 15, forward.
// - secondary target perr on downstream write sets secondary bit 8 if enabled.
// - that report raises primary system error under enables, disable bit, not forwarded.
// - primary target perr on upstream write sets primary bit 8 if enabled.
// - that report raises primary system error under enables when not forwarded.
// - forwarded parity is either passed unchanged or regenerated.
// - misc options bit 3 selects regeneration of outgoing data-phase parity; address-phase parity passes unchanged.
`timescale 1ns/1ps
`default_nettype none
module bpeh_handler #(
	parameter int AD_W = 32,
	parameter int BE_W = 4
) (
	input  wire logic                 clk_sys,
	input  wire logic                 nrst,
	input  wire logic                 cfg_wr,
	input  wire logic                 cfg_rd,
	input  wire logic [7:0]           cfg_addr,
	input  wire logic [31:0]          cfg_wdata,
	input  wire logic [3:0]           cfg_be,
	input  wire logic                 cfg_par,
	output logic [31:0]               cfg_rdata,
	output logic                      cfg_rvalid,
	input  wire logic                 pri_addr_valid,
	input  wire logic                 pri_attr_valid,
	input  wire logic                 pri_pcix_mode,
	input  wire logic [AD_W-1:0]      pri_ad,
	input  wire logic [BE_W-1:0]      pri_cbe,
	input  wire logic                 pri_par,
	input  wire logic                 pri_data_valid,
	input  wire bpeh_pkg::bpeh_kind_t pri_data_kind,
	input  wire logic                 pri_mwr_window,
	input  wire logic                 pri_mwr_fwd_err,
	input  wire logic                 upstream_side_parity_err_n_in,
	output logic                      upstream_side_parity_err_n_out,
	output logic                      upstream_side_parity_err_n_oe_n,
	output logic                      upstream_side_system_err_n_out,
	output logic                      upstream_side_system_err_n_oe_n,
	output logic                      upstream_side_claim_inhibit,
	output logic                      pri_target_abort,
	output logic                      pri_fifo_reject,
	input  wire logic [AD_W-1:0]      pri_out_ad,
	input  wire logic [BE_W-1:0]      pri_out_cbe,
	input  wire logic                 pri_out_par_rx,
	input  wire logic                 pri_out_is_data,
	output logic                      pri_out_par,
	input  wire logic                 sec_addr_valid,
	input  wire logic                 sec_attr_valid,
	input  wire logic                 sec_pcix_mode,
	input  wire logic [AD_W-1:0]      sec_ad,
	input  wire logic [BE_W-1:0]      sec_cbe,
	input  wire logic                 sec_par,
	input  wire logic                 sec_data_valid,
	input  wire bpeh_pkg::bpeh_kind_t sec_data_kind,
	input  wire logic                 sec_mwr_window,
	input  wire logic                 sec_mwr_fwd_err,
	input  wire logic                 downstream_side_parity_err_n_in,
	output logic                      downstream_side_parity_err_n_out,
	output logic                      downstream_side_parity_err_n_oe_n,
	output logic                      downstream_side_system_err_n_out,
	output logic                      downstream_side_system_err_n_oe_n,
	output logic                      downstream_side_claim_inhibit,
	output logic                      sec_target_abort,
	output logic                      sec_fifo_reject,
	input  wire logic [AD_W-1:0]      sec_out_ad,
	input  wire logic [BE_W-1:0]      sec_out_cbe,
	input  wire logic                 sec_out_par_rx,
	input  wire logic                 sec_out_is_data,
	output logic                      sec_out_par
);

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
		return a[7:2] == off[7:2];
	endfunction

	function automatic logic [15:0] lanes16(input logic [31:0] wd, input logic [3:0] be, input logic [7:0] off);
		logic [15:0] v;
		logic [1:0]  m;
		v = off[1] ? wd[31:16] : wd[15:0];
		m = off[1] ? be[3:2] : be[1:0];
		return v & {{8{m[1]}}, {8{m[0]}}};
	endfunction

	function automatic logic [15:0] wr16(input logic [15:0] old, input logic [31:0] wd, input logic [3:0] be,
		input logic [7:0] off);
		logic [1:0]  m;
		m = off[1] ? be[3:2] : be[1:0];
		return (old & ~{{8{m[1]}}, {8{m[0]}}}) | lanes16(wd, be, off);
	endfunction

	function automatic logic [7:0] wr8(input logic [7:0] old, input logic [31:0] wd, input logic [3:0] be,
		input logic [7:0] off);
		return be[off[1:0]] ? wd[8*off[1:0] +: 8] : old;
	endfunction

	// ----------------------------------------
	// per interface parity checkers
	// ----------------------------------------
	logic                 pri_ape;
	logic [BE_W-1:0]      pri_cmd;
	logic                 pri_dpe;
	bpeh_pkg::bpeh_kind_t pri_kind;
	logic                 pri_perr_rise;
	logic                 sec_ape;
	logic [BE_W-1:0]      sec_cmd;
	logic                 sec_dpe;
	bpeh_pkg::bpeh_kind_t sec_kind;
	logic                 sec_perr_rise;

	bpeh_side_chk #(.AD_W(AD_W), .BE_W(BE_W)) u_pri_chk (
		.clk_sys     (clk_sys),
		.nrst        (nrst),
		.addr_valid  (pri_addr_valid),
		.attr_valid  (pri_attr_valid),
		.ad          (pri_ad),
		.cbe         (pri_cbe),
		.par         (pri_par),
		.data_valid  (pri_data_valid),
		.data_kind   (pri_data_kind),
		.perr_pin_n  (upstream_side_parity_err_n_in),
		.addr_err    (pri_ape),
		.cmd         (pri_cmd),
		.data_err    (pri_dpe),
		.data_kind_q (pri_kind),
		.perr_rise   (pri_perr_rise)
	);

	bpeh_side_chk #(.AD_W(AD_W), .BE_W(BE_W)) u_sec_chk (
		.clk_sys     (clk_sys),
		.nrst        (nrst),
		.addr_valid  (sec_addr_valid),
		.attr_valid  (sec_attr_valid),
		.ad          (sec_ad),
		.cbe         (sec_cbe),
		.par         (sec_par),
		.data_valid  (sec_data_valid),
		.data_kind   (sec_data_kind),
		.perr_pin_n  (downstream_side_parity_err_n_in),
		.addr_err    (sec_ape),
		.cmd         (sec_cmd),
		.data_err    (sec_dpe),
		.data_kind_q (sec_kind),
		.perr_rise   (sec_perr_rise)
	);

	// ----------------------------------------
	// configuration registers
	// ----------------------------------------
	logic [15:0] primary_command;
	logic [15:0] primary_status;
	logic [15:0] secondary_status;
	logic [15:0] bridge_control;
	logic [7:0]  misc_options;
	logic [7:0]  syserr_event_disable;
	logic [7:0]  syserr_event_status;
	logic        cfg_perr_q;
	logic [15:0] next_primary_command;
	logic [15:0] next_primary_status;
	logic [15:0] next_secondary_status;
	logic [15:0] next_bridge_control;
	logic [7:0]  next_misc_options;
	logic [7:0]  next_syserr_event_disable;
	logic [7:0]  next_syserr_event_status;
	logic        next_cfg_perr_q;
	logic [31:0] next_cfg_rdata;
	logic        next_cfg_rvalid;

	// ----------------------------------------
	// event decode
	// ----------------------------------------
	logic pri_en;
	logic sec_en;
	logic pserr_en;
	logic cfg_bad;
	logic pri_rd_err;
	logic sec_rd_err;
	logic pri_in_err;
	logic sec_in_err;
	logic dn_wr_report;
	logic up_wr_report;
	logic pri_serr_evt;
	logic sec_serr_evt;

	always_comb begin
		pri_en       = primary_command[bpeh_pkg::CMD_PERR_RESP_BIT];
		sec_en       = bridge_control[bpeh_pkg::BCTL_PERR_RESP_BIT];
		pserr_en     = primary_command[bpeh_pkg::CMD_SERR_EN_BIT] & pri_en;
		cfg_bad      = cfg_wr & (^{cfg_wdata, cfg_be, cfg_par});
		pri_rd_err   = pri_dpe & (pri_kind == bpeh_pkg::BPEH_KIND_MASTER_READ);
		sec_rd_err   = sec_dpe & (sec_kind == bpeh_pkg::BPEH_KIND_MASTER_READ);
		pri_in_err   = pri_rd_err | (pri_dpe & (pri_kind == bpeh_pkg::BPEH_KIND_TARGET_WRITE));
		sec_in_err   = sec_rd_err | (sec_dpe & (sec_kind == bpeh_pkg::BPEH_KIND_TARGET_WRITE));
		// perr seen outside a write window is the initiator's own report: no action
		dn_wr_report = sec_perr_rise & sec_mwr_window;
		up_wr_report = pri_perr_rise & pri_mwr_window;
		pri_serr_evt = (pri_ape & pserr_en)
			| (dn_wr_report & pserr_en & sec_en & ~sec_mwr_fwd_err
				& ~syserr_event_disable[bpeh_pkg::SEDIS_POSTED_WR_BIT])
			| (up_wr_report & pserr_en & sec_en & ~pri_mwr_fwd_err);
		sec_serr_evt = sec_ape;
	end

	always_comb begin
		next_primary_command      = primary_command;
		next_bridge_control       = bridge_control;
		next_misc_options         = misc_options;
		next_syserr_event_disable = syserr_event_disable;
		next_primary_status       = primary_status;
		next_secondary_status     = secondary_status;
		next_syserr_event_status  = syserr_event_status;
		next_cfg_perr_q           = cfg_bad & pri_en;
		// the write lands even when its data parity is bad
		if (cfg_wr) begin
			if (hit(cfg_addr, bpeh_pkg::OFF_PRIMARY_COMMAND))
				next_primary_command = wr16(primary_command, cfg_wdata, cfg_be, bpeh_pkg::OFF_PRIMARY_COMMAND);
			if (hit(cfg_addr, bpeh_pkg::OFF_BRIDGE_CONTROL))
				next_bridge_control = wr16(bridge_control, cfg_wdata, cfg_be, bpeh_pkg::OFF_BRIDGE_CONTROL);
			if (hit(cfg_addr, bpeh_pkg::OFF_MISC_OPTIONS))
				next_misc_options = wr8(misc_options, cfg_wdata, cfg_be, bpeh_pkg::OFF_MISC_OPTIONS);
			if (hit(cfg_addr, bpeh_pkg::OFF_SYSERR_EVT_DISABLE))
				next_syserr_event_disable = wr8(syserr_event_disable, cfg_wdata, cfg_be,
					bpeh_pkg::OFF_SYSERR_EVT_DISABLE);
			if (hit(cfg_addr, bpeh_pkg::OFF_PRIMARY_STATUS))
				next_primary_status = primary_status
					& ~lanes16(cfg_wdata, cfg_be, bpeh_pkg::OFF_PRIMARY_STATUS);
			if (hit(cfg_addr, bpeh_pkg::OFF_SECONDARY_STATUS))
				next_secondary_status = secondary_status
					& ~lanes16(cfg_wdata, cfg_be, bpeh_pkg::OFF_SECONDARY_STATUS);
			if (hit(cfg_addr, bpeh_pkg::OFF_SYSERR_EVT_STATUS))
				next_syserr_event_status = syserr_event_status
					& ~wr8(8'h00, cfg_wdata, cfg_be, bpeh_pkg::OFF_SYSERR_EVT_STATUS);
		end
		// hardware sets win over a same-cycle clear
		if (pri_ape | cfg_bad | pri_in_err)
			next_primary_status[bpeh_pkg::STAT_PERR_DET_BIT] = 1'b1;
		if (sec_ape | sec_in_err)
			next_secondary_status[bpeh_pkg::STAT_PERR_DET_BIT] = 1'b1;
		if (pri_en & (pri_rd_err | up_wr_report))
			next_primary_status[bpeh_pkg::STAT_MDPE_BIT] = 1'b1;
		if (sec_en & (sec_rd_err | dn_wr_report))
			next_secondary_status[bpeh_pkg::STAT_MDPE_BIT] = 1'b1;
		if (pri_serr_evt)
			next_primary_status[bpeh_pkg::STAT_SIG_SERR_BIT] = 1'b1;
		if (sec_serr_evt)
			next_secondary_status[bpeh_pkg::STAT_SIG_SERR_BIT] = 1'b1;
		if (dn_wr_report)
			next_syserr_event_status[bpeh_pkg::SESTAT_POSTED_WR_BIT] = 1'b1;
		next_primary_status      = next_primary_status & bpeh_pkg::STATUS_W1C_MASK;
		next_secondary_status    = next_secondary_status & bpeh_pkg::STATUS_W1C_MASK;
		next_syserr_event_status = next_syserr_event_status & bpeh_pkg::SESTAT_W1C_MASK;
		// read data, unmapped dwords read as zero
		next_cfg_rvalid = cfg_rd;
		next_cfg_rdata  = 32'h0000_0000;
		if (cfg_rd) begin
			if (hit(cfg_addr, bpeh_pkg::OFF_PRIMARY_COMMAND))
				next_cfg_rdata = {primary_status, primary_command};
			else if (hit(cfg_addr, bpeh_pkg::OFF_SECONDARY_STATUS))
				next_cfg_rdata = {secondary_status, 16'h0000};
			else if (hit(cfg_addr, bpeh_pkg::OFF_BRIDGE_CONTROL))
				next_cfg_rdata = {bridge_control, 16'h0000};
			else if (hit(cfg_addr, bpeh_pkg::OFF_MISC_OPTIONS))
				next_cfg_rdata = {8'h00, misc_options, 16'h0000};
			else if (hit(cfg_addr, bpeh_pkg::OFF_SYSERR_EVT_DISABLE))
				next_cfg_rdata = {24'h00_0000, syserr_event_disable};
			else if (hit(cfg_addr, bpeh_pkg::OFF_SYSERR_EVT_STATUS))
				next_cfg_rdata = {8'h00, syserr_event_status, 16'h0000};
			else
				next_cfg_rdata = 32'h0000_0000;
		end
	end

	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			primary_command      <= bpeh_pkg::RST_PRIMARY_COMMAND;
			primary_status       <= bpeh_pkg::RST_STATUS;
			secondary_status     <= bpeh_pkg::RST_STATUS;
			bridge_control       <= bpeh_pkg::RST_BRIDGE_CONTROL;
			misc_options         <= bpeh_pkg::RST_MISC_OPTIONS;
			syserr_event_disable <= bpeh_pkg::RST_SYSERR_DISABLE;
			syserr_event_status  <= bpeh_pkg::RST_SYSERR_STATUS;
			cfg_perr_q           <= 1'b0;
			cfg_rdata            <= 32'h0000_0000;
			cfg_rvalid           <= 1'b0;
		end else begin
			primary_command      <= next_primary_command;
			primary_status       <= next_primary_status;
			secondary_status     <= next_secondary_status;
			bridge_control       <= next_bridge_control;
			misc_options         <= next_misc_options;
			syserr_event_disable <= next_syserr_event_disable;
			syserr_event_status  <= next_syserr_event_status;
			cfg_perr_q           <= next_cfg_perr_q;
			cfg_rdata            <= next_cfg_rdata;
			cfg_rvalid           <= next_cfg_rvalid;
		end
	end

	// ----------------------------------------
	// pins, address responses and forwarding
	// ----------------------------------------
	logic next_pri_perr;
	logic next_sec_perr;
	logic next_pri_claim_inh;
	logic next_pri_abort;
	logic next_pri_reject;
	logic next_sec_claim_inh;
	logic next_sec_abort;
	logic next_sec_reject;
	logic next_pri_out_par;
	logic next_sec_out_par;
	logic regen;

	always_comb begin
		// error flags land one clock after the data, so this flop lands two after
		next_pri_perr      = (pri_in_err & pri_en) | cfg_perr_q;
		next_sec_perr      = sec_in_err & sec_en;
		next_pri_claim_inh = pri_ape & ~pri_pcix_mode & pri_en;
		next_sec_claim_inh = sec_ape & ~sec_pcix_mode & sec_en;
		next_pri_abort     = pri_ape & pri_pcix_mode & (pri_cmd != bpeh_pkg::CMD_SPLIT_COMPLETION);
		next_sec_abort     = sec_ape & sec_pcix_mode & (sec_cmd != bpeh_pkg::CMD_SPLIT_COMPLETION);
		next_pri_reject    = pri_ape & pri_pcix_mode;
		next_sec_reject    = sec_ape & sec_pcix_mode;
		regen              = misc_options[bpeh_pkg::MISC_REGEN_PAR_BIT];
		// read data and posted data keep the received parity unless regeneration is on
		next_pri_out_par   = (regen & pri_out_is_data) ? ^{pri_out_ad, pri_out_cbe} : pri_out_par_rx;
		next_sec_out_par   = (regen & sec_out_is_data) ? ^{sec_out_ad, sec_out_cbe} : sec_out_par_rx;
	end

	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			upstream_side_parity_err_n_out    <= 1'b1;
			upstream_side_parity_err_n_oe_n   <= 1'b1;
			downstream_side_parity_err_n_out  <= 1'b1;
			downstream_side_parity_err_n_oe_n <= 1'b1;
			upstream_side_system_err_n_out    <= 1'b1;
			upstream_side_system_err_n_oe_n   <= 1'b1;
			downstream_side_system_err_n_out  <= 1'b1;
			downstream_side_system_err_n_oe_n <= 1'b1;
			upstream_side_claim_inhibit       <= 1'b0;
			downstream_side_claim_inhibit     <= 1'b0;
			pri_target_abort                  <= 1'b0;
			sec_target_abort                  <= 1'b0;
			pri_fifo_reject                   <= 1'b0;
			sec_fifo_reject                   <= 1'b0;
			pri_out_par                       <= 1'b0;
			sec_out_par                       <= 1'b0;
		end else begin
			upstream_side_parity_err_n_out    <= ~next_pri_perr;
			upstream_side_parity_err_n_oe_n   <= ~next_pri_perr;
			downstream_side_parity_err_n_out  <= ~next_sec_perr;
			downstream_side_parity_err_n_oe_n <= ~next_sec_perr;
			upstream_side_system_err_n_out    <= ~pri_serr_evt;
			upstream_side_system_err_n_oe_n   <= ~pri_serr_evt;
			downstream_side_system_err_n_out  <= ~sec_serr_evt;
			downstream_side_system_err_n_oe_n <= ~sec_serr_evt;
			upstream_side_claim_inhibit       <= next_pri_claim_inh;
			downstream_side_claim_inhibit     <= next_sec_claim_inh;
			pri_target_abort                  <= next_pri_abort;
			sec_target_abort                  <= next_sec_abort;
			pri_fifo_reject                   <= next_pri_reject;
			sec_fifo_reject                   <= next_sec_reject;
			pri_out_par                       <= next_pri_out_par;
			sec_out_par                       <= next_sec_out_par;
		end
	end

endmodule
`default_nettype wire

/* File: verification/bpeh_handler_sva.sv */
`timescale 1ns/1ps
`default_nettype none
module bpeh_handler_sva #(parameter int AD_W = 32, parameter int BE_W = 4) (
	input wire logic            clk_sys, nrst, pri_addr_valid, pri_pcix_mode, pri_par, sec_addr_valid, sec_par,
	input wire logic [AD_W-1:0] pri_ad, sec_ad,
	input wire logic [BE_W-1:0] pri_cbe, sec_cbe,
	input wire logic            sec_data_valid, upstream_side_claim_inhibit, pri_target_abort, pri_fifo_reject,
	input wire logic            downstream_side_parity_err_n_out, downstream_side_parity_err_n_oe_n,
	input wire logic            downstream_side_system_err_n_oe_n
);
	// ----
	// address and data parity responses
	// ----
	wire logic pbad = pri_addr_valid & ^{pri_ad, pri_cbe, pri_par};
	wire logic sbad = sec_addr_valid & ^{sec_ad, sec_cbe, sec_par};
	wire logic psplit = pbad & pri_pcix_mode & (pri_cbe == bpeh_pkg::CMD_SPLIT_COMPLETION);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!nrst);
	sequence two_on(s); ##2 s; endsequence
	inhibit_cause_a: assert property (upstream_side_claim_inhibit |-> $past(pbad, 2))
		else $error("claim inhibit without address error");
	abort_other_a: assert property (pbad && pri_pcix_mode && !psplit |-> two_on(pri_target_abort && pri_fifo_reject))
		else $error("pci-x address error not aborted");
	split_recv_a: assert property (psplit |-> two_on(!pri_target_abort && pri_fifo_reject))
		else $error("split completion mishandled");
	no_inhibit_a: assert property (pbad && pri_pcix_mode |-> two_on(!upstream_side_claim_inhibit))
		else $error("claim inhibited in pci-x mode");
	sec_serr_a: assert property (sbad |-> two_on(!downstream_side_system_err_n_oe_n))
		else $error("secondary system error missing");
	serr_cause_a: assert property ($fell(downstream_side_system_err_n_oe_n) |-> $past(sbad, 2))
		else $error("secondary system error without cause");
	sec_perr_a: assert property (!downstream_side_parity_err_n_oe_n |-> $past(sec_data_valid, 2))
		else $error("secondary parity error without data phase");
	perr_pair_a: assert property (!downstream_side_parity_err_n_oe_n |-> !downstream_side_parity_err_n_out)
		else $error("secondary parity error driven high");
endmodule
`default_nettype wire

/* File: verification/bpeh_far_target.sv */
`timescale 1ns/1ps
`default_nettype none
module bpeh_far_target (
	input  wire logic clk_sys,
	input  wire logic far_report,
	input  wire logic downstream_side_parity_err_n_out,
	input  wire logic downstream_side_parity_err_n_oe_n,
	output wire logic downstream_side_parity_err_n_in
);
	// ----
	// target flags bad write data two clocks after the data phase
	// ----
	logic [1:0] dly = 2'b00;
	always @(posedge clk_sys) dly <= {dly[0], far_report};
	// pulled-up wire, low while either party drives low
	assign downstream_side_parity_err_n_in = !dly[1] & (downstream_side_parity_err_n_oe_n | downstream_side_parity_err_n_out);
endmodule
`default_nettype wire

/* File: verification/bridge_parity_error_handler_test.sv */
`timescale 1ns/1ps
`default_nettype none
module bridge_parity_error_handler_test;
	logic        clk_sys = 0, nrst = 0, cfg_wr = 0, cfg_rd = 0, cfg_par = 0, far_report = 0, cfg_rvalid;
	logic [7:0]  cfg_addr = 8'h00;
	logic [3:0]  cfg_be = 4'hF, pri_cbe = 4'h0, sec_cbe = 4'h0, pri_out_cbe = 4'h0, sec_out_cbe = 4'h0;
	logic [31:0] cfg_wdata = 0, pri_ad = 0, sec_ad = 0, pri_out_ad = 0, sec_out_ad = 0, cfg_rdata;
	logic        pri_addr_valid = 0, pri_attr_valid = 0, pri_pcix_mode = 0, pri_par = 0, pri_data_valid = 0;
	logic        sec_addr_valid = 0, sec_attr_valid = 0, sec_pcix_mode = 0, sec_par = 0, sec_data_valid = 0;
	logic        pri_mwr_window = 0, pri_mwr_fwd_err = 0, pri_out_par_rx = 0, pri_out_is_data = 0, pri_out_par;
	logic        sec_mwr_window = 0, sec_mwr_fwd_err = 0, sec_out_par_rx = 0, sec_out_is_data = 0, sec_out_par;
	logic        upstream_side_parity_err_n_in = 1, upstream_side_parity_err_n_out, upstream_side_parity_err_n_oe_n;
	logic        upstream_side_system_err_n_out, upstream_side_system_err_n_oe_n, upstream_side_claim_inhibit;
	logic        downstream_side_parity_err_n_out, downstream_side_parity_err_n_oe_n, downstream_side_system_err_n_out;
	logic        downstream_side_system_err_n_oe_n, downstream_side_claim_inhibit, pri_target_abort, pri_fifo_reject;
	logic        sec_target_abort, sec_fifo_reject;
	wire logic   downstream_side_parity_err_n_in;
	bpeh_pkg::bpeh_kind_t pri_data_kind = bpeh_pkg::BPEH_KIND_NONE, sec_data_kind = bpeh_pkg::BPEH_KIND_NONE;
	int          mismatches = 0, checks = 0;
	bpeh_handler DUT (.*);
	bpeh_far_target far (.*);
	// ----
	// access tasks
	// ----
	task s(int n = 1); repeat (n) @(posedge clk_sys); #1; endtask
	task cmp(logic [32:0] got, logic [32:0] exp);
		checks++;
		if (got !== exp) begin
			mismatches++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task stop_test;
		if (mismatches == 0 && checks > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	task wr(logic [7:0] a, logic [31:0] d, logic [3:0] be = 4'hF, logic bad = 0);
		{cfg_addr, cfg_wdata, cfg_be, cfg_par, cfg_wr} = {a, d, be, ^{d, be} ^ bad, 1'b1};
		s();
		cfg_wr = 0;
		s();
	endtask
	task rd(logic [7:0] a, logic [31:0] exp);
		{cfg_addr, cfg_rd} = {a, 1'b1};
		s();
		cfg_rd = 0;
		cmp({cfg_rvalid, cfg_rdata}, {1'b1, exp});
		s();
	endtask
	// bad address phase, result is {inhibit, abort, reject, system error}
	task ap(logic sc, logic x, logic [3:0] c, logic [3:0] exp);
		{pri_pcix_mode, sec_pcix_mode, pri_cbe, sec_cbe, pri_par, sec_par, pri_addr_valid, sec_addr_valid} =
			{x, x, c, c, !(^c), !(^c), !sc, sc};
		s();
		{pri_addr_valid, sec_addr_valid} = 2'b00;
		s();
		cmp(sc ? {downstream_side_claim_inhibit, sec_target_abort, sec_fifo_reject, !downstream_side_system_err_n_oe_n}
			: {upstream_side_claim_inhibit, pri_target_abort, pri_fifo_reject, !upstream_side_system_err_n_oe_n}, exp);
	endtask
	task dp(logic sc, bpeh_pkg::bpeh_kind_t k, logic exp_n);
		pri_data_kind = k;
		sec_data_kind = k;
		{pri_cbe, sec_cbe, pri_par, sec_par, pri_data_valid, sec_data_valid} = {8'h00, 2'b11, !sc, sc};
		s();
		{pri_data_valid, sec_data_valid} = 2'b00;
		s();
		cmp(sc ? downstream_side_parity_err_n_oe_n : upstream_side_parity_err_n_oe_n, exp_n);
	endtask
	initial forever #12.5 clk_sys = !clk_sys;
	initial begin
		#20us;
		mismatches++;
		stop_test();
	end
	initial begin
		s(20);
		nrst = 1;
		rd(8'h04, 32'h0000_0000);
		wr(8'h3C, 32'h0001_0000, 4'hC);
		wr(8'h04, 32'h0000_0140);
		ap(0, 0, 4'h6, 4'b1001);
		ap(0, 1, 4'hC, 4'b0011);
		ap(1, 1, 4'h6, 4'b0111);
		rd(8'h04, 32'hC000_0140);
		rd(8'h1C, 32'hC000_0000);
		wr(8'h04, 32'hC000_0140);
		rd(8'h04, 32'h0000_0140);
		wr(8'h04, 32'h0000_0140, 4'hF, 1);
		cmp(upstream_side_parity_err_n_oe_n, 0);
		rd(8'h04, 32'h8000_0140);
		dp(1, bpeh_pkg::BPEH_KIND_MASTER_READ, 0);
		rd(8'h1C, 32'hC100_0000);
		wr(8'h1C, 32'hC100_0000);
		{sec_mwr_window, far_report} = 2'b11;
		s();
		far_report = 0;
		s(8);
		sec_mwr_window = 0;
		rd(8'h1C, 32'h0100_0000);
		rd(8'h04, 32'hC000_0140);
		wr(8'h04, 32'h0000_0000);
		ap(0, 0, 4'h6, 4'b0000);
		dp(0, bpeh_pkg::BPEH_KIND_TARGET_WRITE, 1);
		{pri_out_par_rx, pri_out_is_data, sec_out_par_rx, sec_out_is_data} = 4'hF;
		s();
		cmp({pri_out_par, sec_out_par}, 2'b11);
		wr(8'h44, 32'h0008_0000, 4'h4);
		cmp({pri_out_par, sec_out_par}, 2'b00);
		stop_test();
	end
endmodule
bind bpeh_handler bpeh_handler_sva #(.AD_W(AD_W), .BE_W(BE_W)) chk (.*);
`default_nettype wire
